// *** rtl/synth_divider_output_config.sv ***
`timescale 1ns/1ps

// Function
// - Margin offset bits 9:2 register, reset 0x80
// - Margin offset bits 1:0 in preceding register
// - Format select: tristate, LVPECL, LVDS, HCSL
// - Nine-bit output divider across two registers
// - Output divider 5..511 exact; 0-4 reserved
// - Output divider resets to thirty-two
// - Twelve-bit feedback divider across two registers
// - Feedback divider resets to fifty
// - Twenty-two-bit numerator, three registers, MSB first
// - Twenty-two-bit denominator, three registers, MSB first
// - Rising trigger starts calibration; self-clears
module synth_divider_output_config #(
	parameter int OUT_DIV_WIDTH = 9,
	parameter int FB_DIV_WIDTH  = 12,
	parameter int FRAC_WIDTH    = 22
) (
	input  wire logic                     clk_sys_in,
	input  wire logic                     rst_b_in,
	input  wire logic [7:0]               reg_addr_in,
	input  wire logic [7:0]               reg_wdata_in,
	input  wire logic                     reg_write_in,
	input  wire logic                     reg_read_in,
	input  wire logic                     cal_done_in,
	output logic      [7:0]               reg_rdata_out,
	output logic                          reg_rvalid_out,
	output logic      [9:0]               crystal_margin_offset_out,
	output logic                          output_buffer_powerdown_out,
	output logic      [1:0]               out_format_out,
	output logic                          out_tristate_out,
	output logic      [OUT_DIV_WIDTH-1:0] output_divider_out,
	output logic                          output_divider_legal_out,
	output logic                          output_tick_out,
	output logic      [FB_DIV_WIDTH-1:0]  feedback_integer_ratio_out,
	output logic      [FRAC_WIDTH-1:0]    fraction_numerator_out,
	output logic      [FRAC_WIDTH-1:0]    fraction_denominator_out,
	output logic                          fraction_active_out,
	output logic                          calibration_start_out,
	output logic                          calibration_busy_out
);

	// ------------------------------------------------------------
	// State
	// ------------------------------------------------------------
	typedef struct packed {
		logic [1:0]                  margin_low;
		logic [7:0]                  margin_high;
		logic                        powerdown;
		synth_cfg_pkg::out_format_e  out_format;
		logic                        tristate;
		logic [7:0]                  out_div_hi;
		logic [7:0]                  out_div_lo;
		logic [3:0]                  fb_div_hi;
		logic [7:0]                  fb_div_lo;
		logic [FRAC_WIDTH-1:0]       numer;
		logic [FRAC_WIDTH-1:0]       denom;
		logic                        frac_active;
		logic                        cal_trigger;
		synth_cfg_pkg::cal_state_e   cal_state;
		logic                        cal_start;
		logic                        done_meta;
		logic                        done_sync;
		logic                        done_prev;
		logic [7:0]                  rdata;
		logic                        rvalid;
	} cfg_state_s;

	cfg_state_s state;
	cfg_state_s next_state;

	logic div_tick;
	logic div_legal;
	logic done_rise;

	// ------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------
	function automatic logic hit(input logic [7:0] addr, input logic [7:0] offset);
		hit = (addr == offset);
	endfunction : hit

	function automatic logic [7:0] top_byte(input logic [FRAC_WIDTH-1:0] value);
		top_byte = {2'h0, value[21:16]};
	endfunction : top_byte

	function automatic logic [7:0] read_mux(input cfg_state_s s, input logic [7:0] addr);
		read_mux = 8'h00;
		case (addr)
			synth_cfg_pkg::CAL_CTRL_OFFSET:    read_mux = {6'h00, s.cal_trigger, 1'b0};
			synth_cfg_pkg::MARGIN_LOW_OFFSET:  read_mux = {6'h00, s.margin_low};
			synth_cfg_pkg::MARGIN_HIGH_OFFSET: read_mux = s.margin_high;
			synth_cfg_pkg::DRV_CTRL_OFFSET:    read_mux = {s.powerdown, 5'h00, s.out_format};
			synth_cfg_pkg::OUT_DIV_HI_OFFSET:  read_mux = s.out_div_hi;
			synth_cfg_pkg::OUT_DIV_LO_OFFSET:  read_mux = s.out_div_lo;
			synth_cfg_pkg::FB_DIV_HI_OFFSET:   read_mux = {4'h0, s.fb_div_hi};
			synth_cfg_pkg::FB_DIV_LO_OFFSET:   read_mux = s.fb_div_lo;
			synth_cfg_pkg::NUM_TOP_OFFSET:     read_mux = top_byte(s.numer);
			synth_cfg_pkg::NUM_MID_OFFSET:     read_mux = s.numer[15:8];
			synth_cfg_pkg::NUM_LOW_OFFSET:     read_mux = s.numer[7:0];
			synth_cfg_pkg::DEN_TOP_OFFSET:     read_mux = top_byte(s.denom);
			synth_cfg_pkg::DEN_MID_OFFSET:     read_mux = s.denom[15:8];
			synth_cfg_pkg::DEN_LOW_OFFSET:     read_mux = s.denom[7:0];
			default:                           read_mux = 8'h00;
		endcase
	endfunction : read_mux

	// Rise is taken from the second stage against the third (done_prev)
	assign done_rise = state.done_sync && !state.done_prev;

	// ------------------------------------------------------------
	// Next state
	// ------------------------------------------------------------
	always_comb begin
		next_state           = state;
		next_state.cal_start = 1'b0;
		next_state.rvalid    = 1'b0;
		next_state.done_meta = cal_done_in;
		next_state.done_sync = state.done_meta;
		next_state.done_prev = state.done_sync;

		if (reg_write_in) begin
			if (hit(reg_addr_in, synth_cfg_pkg::MARGIN_LOW_OFFSET)) begin
				next_state.margin_low = reg_wdata_in[1:0];
			end
			if (hit(reg_addr_in, synth_cfg_pkg::MARGIN_HIGH_OFFSET)) begin
				next_state.margin_high = reg_wdata_in;
			end
			if (hit(reg_addr_in, synth_cfg_pkg::DRV_CTRL_OFFSET)) begin
				next_state.powerdown  = reg_wdata_in[synth_cfg_pkg::POWERDOWN_BIT];
				next_state.out_format = synth_cfg_pkg::out_format_e'(reg_wdata_in[1:0]);
			end
			if (hit(reg_addr_in, synth_cfg_pkg::OUT_DIV_HI_OFFSET)) begin
				next_state.out_div_hi = reg_wdata_in;
			end
			if (hit(reg_addr_in, synth_cfg_pkg::OUT_DIV_LO_OFFSET)) begin
				next_state.out_div_lo = reg_wdata_in;
			end
			if (hit(reg_addr_in, synth_cfg_pkg::FB_DIV_HI_OFFSET)) begin
				next_state.fb_div_hi = reg_wdata_in[3:0];
			end
			if (hit(reg_addr_in, synth_cfg_pkg::FB_DIV_LO_OFFSET)) begin
				next_state.fb_div_lo = reg_wdata_in;
			end
			if (hit(reg_addr_in, synth_cfg_pkg::NUM_TOP_OFFSET)) begin
				next_state.numer[21:16] = reg_wdata_in[5:0];
			end
			if (hit(reg_addr_in, synth_cfg_pkg::NUM_MID_OFFSET)) begin
				next_state.numer[15:8] = reg_wdata_in;
			end
			if (hit(reg_addr_in, synth_cfg_pkg::NUM_LOW_OFFSET)) begin
				next_state.numer[7:0] = reg_wdata_in;
			end
			if (hit(reg_addr_in, synth_cfg_pkg::DEN_TOP_OFFSET)) begin
				next_state.denom[21:16] = reg_wdata_in[5:0];
			end
			if (hit(reg_addr_in, synth_cfg_pkg::DEN_MID_OFFSET)) begin
				next_state.denom[15:8] = reg_wdata_in;
			end
			if (hit(reg_addr_in, synth_cfg_pkg::DEN_LOW_OFFSET)) begin
				next_state.denom[7:0] = reg_wdata_in;
			end
		end

		// ------------------------------------------------------------
		// Calibration sequencer
		// ------------------------------------------------------------
		case (state.cal_state)
			synth_cfg_pkg::CAL_IDLE: begin
				if (reg_write_in && hit(reg_addr_in, synth_cfg_pkg::CAL_CTRL_OFFSET)
					&& reg_wdata_in[synth_cfg_pkg::CAL_TRIGGER_BIT]
					&& !state.cal_trigger) begin
					next_state.cal_trigger = 1'b1;
					next_state.cal_start   = 1'b1;
					next_state.cal_state   = synth_cfg_pkg::CAL_RUN;
				end
			end
			synth_cfg_pkg::CAL_RUN: begin
				// Writes while running cannot clear the bit: only completion does
				if (done_rise) begin
					next_state.cal_trigger = 1'b0;
					next_state.cal_state   = synth_cfg_pkg::CAL_IDLE;
				end
			end
			default: begin
				next_state.cal_trigger = 1'b0;
				next_state.cal_state   = synth_cfg_pkg::CAL_IDLE;
			end
		endcase

		// ------------------------------------------------------------
		// Derived outputs, registered
		// ------------------------------------------------------------
		next_state.tristate = (next_state.out_format == synth_cfg_pkg::FMT_TRISTATE);
		// Zero denominator would be a divide by zero, so integer mode is used instead
		next_state.frac_active = (next_state.numer != '0) && (next_state.denom != '0);

		if (reg_read_in) begin
			next_state.rdata  = read_mux(state, reg_addr_in);
			next_state.rvalid = 1'b1;
		end
	end

	always_ff @(posedge clk_sys_in) begin
		if (!rst_b_in) begin
			state             <= '0;
			state.margin_low  <= synth_cfg_pkg::MARGIN_LOW_RESET;
			state.margin_high <= synth_cfg_pkg::MARGIN_HIGH_RESET;
			state.out_format  <= synth_cfg_pkg::out_format_e'(synth_cfg_pkg::OUT_FORMAT_RESET);
			state.out_div_hi  <= synth_cfg_pkg::OUT_DIV_HI_RESET;
			state.out_div_lo  <= synth_cfg_pkg::OUT_DIV_LO_RESET;
			state.fb_div_hi   <= synth_cfg_pkg::FB_DIV_HI_RESET;
			state.fb_div_lo   <= synth_cfg_pkg::FB_DIV_LO_RESET;
			state.numer       <= synth_cfg_pkg::FRACTION_RESET;
			state.denom       <= synth_cfg_pkg::FRACTION_RESET;
			state.cal_state   <= synth_cfg_pkg::CAL_IDLE;
		end else begin
			state <= next_state;
		end
	end

	// ------------------------------------------------------------
	// Output divider
	// ------------------------------------------------------------
	output_divider_tick #(
		.DIV_WIDTH (OUT_DIV_WIDTH)
	) u_out_div (
		.clk_sys_in (clk_sys_in),
		.rst_b_in   (rst_b_in),
		.run_in     (!state.powerdown && !state.tristate),
		.divide_in  ({state.out_div_hi[0], state.out_div_lo}),
		.tick_out   (div_tick),
		.legal_out  (div_legal)
	);

	// ------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------
	assign reg_rdata_out               = state.rdata;
	assign reg_rvalid_out              = state.rvalid;
	assign crystal_margin_offset_out   = {state.margin_high, state.margin_low};
	assign output_buffer_powerdown_out = state.powerdown;
	assign out_format_out              = state.out_format;
	assign out_tristate_out            = state.tristate;
	assign output_divider_out          = {state.out_div_hi[0], state.out_div_lo};
	assign output_divider_legal_out    = div_legal;
	assign output_tick_out             = div_tick;
	assign feedback_integer_ratio_out  = {state.fb_div_hi, state.fb_div_lo};
	assign fraction_numerator_out      = state.numer;
	assign fraction_denominator_out    = state.denom;
	assign fraction_active_out         = state.frac_active;
	assign calibration_start_out       = state.cal_start;
	assign calibration_busy_out        = state.cal_trigger;

endmodule : synth_divider_output_config

// *** common/synth_cfg_pkg.sv ***
package synth_cfg_pkg;

	// ------------------------------------------------------------
	// Register offsets
	// ------------------------------------------------------------
	localparam logic [7:0] CAL_CTRL_OFFSET    = 8'h0A;
	localparam logic [7:0] MARGIN_LOW_OFFSET  = 8'h10;
	localparam logic [7:0] MARGIN_HIGH_OFFSET = 8'h11;
	localparam logic [7:0] DRV_CTRL_OFFSET    = 8'h15;
	localparam logic [7:0] OUT_DIV_HI_OFFSET  = 8'h16;
	localparam logic [7:0] OUT_DIV_LO_OFFSET  = 8'h17;
	localparam logic [7:0] FB_DIV_HI_OFFSET   = 8'h19;
	localparam logic [7:0] FB_DIV_LO_OFFSET   = 8'h1A;
	localparam logic [7:0] NUM_TOP_OFFSET     = 8'h1B;
	localparam logic [7:0] NUM_MID_OFFSET     = 8'h1C;
	localparam logic [7:0] NUM_LOW_OFFSET     = 8'h1D;
	localparam logic [7:0] DEN_TOP_OFFSET     = 8'h1E;
	localparam logic [7:0] DEN_MID_OFFSET     = 8'h1F;
	localparam logic [7:0] DEN_LOW_OFFSET     = 8'h20;

	// ------------------------------------------------------------
	// Field positions
	// ------------------------------------------------------------
	localparam int CAL_TRIGGER_BIT = 1;
	localparam int POWERDOWN_BIT   = 7;

	// ------------------------------------------------------------
	// Reset values
	// ------------------------------------------------------------
	localparam logic [7:0] MARGIN_HIGH_RESET = 8'h80;
	localparam logic [1:0] MARGIN_LOW_RESET  = 2'h0;
	localparam logic [1:0] OUT_FORMAT_RESET  = 2'h1;
	localparam logic [7:0] OUT_DIV_HI_RESET  = 8'h00;
	localparam logic [7:0] OUT_DIV_LO_RESET  = 8'h20;
	localparam logic [3:0] FB_DIV_HI_RESET   = 4'h0;
	localparam logic [7:0] FB_DIV_LO_RESET   = 8'h32;
	localparam logic [21:0] FRACTION_RESET   = 22'h000000;

	// ------------------------------------------------------------
	// Counts
	// ------------------------------------------------------------
	localparam logic [8:0] OUT_DIV_MIN = 9'h005;

	// ------------------------------------------------------------
	// Enumerations
	// ------------------------------------------------------------
	typedef enum logic [1:0] {
		FMT_TRISTATE = 2'b00,
		FMT_LVPECL   = 2'b01,
		FMT_LVDS     = 2'b10,
		FMT_HCSL     = 2'b11
	} out_format_e;

	typedef enum logic {
		CAL_IDLE = 1'b0,
		CAL_RUN  = 1'b1
	} cal_state_e;

endpackage : synth_cfg_pkg

// *** rtl/output_divider_tick.sv ***
`timescale 1ns/1ps

module output_divider_tick #(
	parameter int DIV_WIDTH = 9
) (
	input  wire logic                 clk_sys_in,
	input  wire logic                 rst_b_in,
	input  wire logic                 run_in,
	input  wire logic [DIV_WIDTH-1:0] divide_in,
	output logic                      tick_out,
	output logic                      legal_out
);

	typedef struct packed {
		logic [DIV_WIDTH-1:0] count;
		logic                 tick;
		logic                 legal;
	} div_state_s;

	div_state_s state;
	div_state_s next_state;

	// ------------------------------------------------------------
	// Counter
	// ------------------------------------------------------------
	always_comb begin
		next_state       = state;
		next_state.tick  = 1'b0;
		next_state.legal = (divide_in >= DIV_WIDTH'(synth_cfg_pkg::OUT_DIV_MIN));
		// Reserved settings clear the counter to zero rather than divide wrongly
		if (!run_in || !next_state.legal) begin
			next_state.count = '0;
		end else if (state.count >= divide_in - DIV_WIDTH'(1)) begin
			next_state.count = '0;
			next_state.tick  = 1'b1;
		end else begin
			next_state.count = state.count + DIV_WIDTH'(1);
		end
	end

	always_ff @(posedge clk_sys_in) begin
		if (!rst_b_in) begin
			state <= '0;
		end else begin
			state <= next_state;
		end
	end

	assign tick_out  = state.tick;
	assign legal_out = state.legal;

endmodule : output_divider_tick

// *** verification/synth_cfg_checker.sv ***
`timescale 1ns/1ps

module synth_cfg_checker #(
	parameter int OUT_DIV_WIDTH = 9,
	parameter int FB_DIV_WIDTH  = 12,
	parameter int FRAC_WIDTH    = 22
) (
	input wire logic                     clk_sys_in,
	input wire logic                     rst_b_in,
	input wire logic [7:0]               reg_addr_in,
	input wire logic [7:0]               reg_wdata_in,
	input wire logic                     reg_write_in,
	input wire logic [9:0]               crystal_margin_offset_out,
	input wire logic [1:0]               out_format_out,
	input wire logic                     out_tristate_out,
	input wire logic [OUT_DIV_WIDTH-1:0] output_divider_out,
	input wire logic                     output_tick_out,
	input wire logic [FB_DIV_WIDTH-1:0]  feedback_integer_ratio_out,
	input wire logic [FRAC_WIDTH-1:0]    fraction_numerator_out,
	input wire logic [FRAC_WIDTH-1:0]    fraction_denominator_out,
	input wire logic                     calibration_start_out,
	input wire logic                     calibration_busy_out
);
	default clocking cb @(posedge clk_sys_in);
	endclocking
	default disable iff (!rst_b_in);

	// --------
	// Sequences
	// --------
	sequence wr_at(logic [7:0] a);
		reg_write_in && reg_addr_in == a;
	endsequence
	sequence cal_arm;
		wr_at(8'h0A) ##0 (reg_wdata_in[1] && !calibration_busy_out);
	endsequence
	// Start is a single pulse while busy holds
	sequence cal_begin;
		calibration_start_out && calibration_busy_out ##1 !calibration_start_out;
	endsequence

	// --------
	// Assertions
	// --------
	AST_MARGIN_HIGH: assert property (wr_at(8'h11)
		|=> crystal_margin_offset_out[9:2] == $past(reg_wdata_in)) else $error("margin high");
	AST_MARGIN_LOW: assert property (wr_at(8'h10)
		|=> crystal_margin_offset_out[1:0] == $past(reg_wdata_in[1:0])) else $error("margin low");
	AST_FORMAT: assert property (wr_at(8'h15)
		|=> out_format_out == $past(reg_wdata_in[1:0])) else $error("format");
	// Tristate flag is registered in the same cycle as the format it decodes
	AST_TRISTATE: assert property (out_tristate_out == (out_format_out == 2'h0))
		else $error("tristate");
	AST_DIV_LOW: assert property (wr_at(8'h17)
		|=> output_divider_out[7:0] == $past(reg_wdata_in)) else $error("divider low");
	AST_NO_TICK: assert property ((output_divider_out < 9'h005)[*3]
		|-> !output_tick_out) else $error("tick on reserved divider");
	AST_FB_HIGH: assert property (wr_at(8'h19)
		|=> feedback_integer_ratio_out[11:8] == $past(reg_wdata_in[3:0])) else $error("feedback");
	AST_NUM_LOW: assert property (wr_at(8'h1D)
		|=> fraction_numerator_out[7:0] == $past(reg_wdata_in)) else $error("numerator");
	AST_DEN_LOW: assert property (wr_at(8'h20)
		|=> fraction_denominator_out[7:0] == $past(reg_wdata_in)) else $error("denominator");
	AST_CAL_START: assert property (cal_arm |=> cal_begin)
		else $error("calibration start");
	AST_CAL_REFUSE: assert property (calibration_busy_out ##0 wr_at(8'h0A)
		|=> !calibration_start_out) else $error("start while busy");
endmodule : synth_cfg_checker

// *** verification/tb.sv ***
`timescale 1ns/1ps

module tb;
	logic        clk_sys_in;
	logic        rst_b_in;
	logic [7:0]  reg_addr_in;
	logic [7:0]  reg_wdata_in;
	logic        reg_write_in;
	logic        reg_read_in;
	logic        cal_done_in;
	logic [7:0]  reg_rdata_out;
	logic        reg_rvalid_out;
	logic [9:0]  crystal_margin_offset_out;
	logic        output_buffer_powerdown_out;
	logic [1:0]  out_format_out;
	logic        out_tristate_out;
	logic [8:0]  output_divider_out;
	logic        output_divider_legal_out;
	logic        output_tick_out;
	logic [11:0] feedback_integer_ratio_out;
	logic [21:0] fraction_numerator_out;
	logic [21:0] fraction_denominator_out;
	logic        fraction_active_out;
	logic        calibration_start_out;
	logic        calibration_busy_out;
	int          mismatches;
	int          compares;

	synth_divider_output_config dut (.clk_sys_in, .rst_b_in, .reg_addr_in, .reg_wdata_in,
		.reg_write_in, .reg_read_in, .cal_done_in, .reg_rdata_out, .reg_rvalid_out,
		.crystal_margin_offset_out, .output_buffer_powerdown_out, .out_format_out,
		.out_tristate_out, .output_divider_out, .output_divider_legal_out,
		.output_tick_out, .feedback_integer_ratio_out, .fraction_numerator_out,
		.fraction_denominator_out, .fraction_active_out, .calibration_start_out,
		.calibration_busy_out);

	// --------
	// Bus tasks
	// --------
	task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			mismatches++;
			$display("Error %s expected %0h seen %0h", what, exp, seen);
		end
	endtask : chk
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge clk_sys_in);
		reg_addr_in  = a;
		reg_wdata_in = d;
		reg_write_in = 1'b1;
		@(negedge clk_sys_in);
		reg_write_in = 1'b0;
	endtask : wr
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(negedge clk_sys_in);
		reg_addr_in = a;
		reg_read_in = 1'b1;
		@(negedge clk_sys_in);
		reg_read_in = 1'b0;
		chk("read valid", reg_rvalid_out, 1'b1);
		d = reg_rdata_out;
	endtask : rd

	// --------
	// Scenarios
	// --------
	task automatic t_reset();
		logic [7:0] offs [13] = '{8'h11, 8'h10, 8'h15, 8'h16, 8'h17, 8'h19, 8'h1A,
			8'h1B, 8'h1C, 8'h1D, 8'h1E, 8'h1F, 8'h20};
		logic [7:0] vals [13] = '{8'h80, 8'h00, 8'h01, 8'h00, 8'h20, 8'h00, 8'h32,
			8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
		logic [7:0] d;
		chk("margin", crystal_margin_offset_out, 10'h200);
		chk("divider", output_divider_out, 9'h020);
		chk("feedback", feedback_integer_ratio_out, 12'h032);
		for (int i = 0; i < 13; i++) begin
			rd(offs[i], d);
			chk("reset byte", {offs[i], d}, {offs[i], vals[i]});
		end
		chk("legal", output_divider_legal_out, 1'b1);
	endtask : t_reset
	task automatic t_fields();
		logic [7:0] d;
		wr(8'h11, 8'hA5);
		wr(8'h10, 8'hFF);
		chk("margin", crystal_margin_offset_out, 10'h297);
		rd(8'h10, d);
		chk("margin low read", d, 8'h03);
		for (int f = 0; f < 4; f++) begin
			wr(8'h15, {f[0], 5'h00, f[1:0]});
			@(negedge clk_sys_in);
			chk("format", out_format_out, f[1:0]);
			chk("tristate", out_tristate_out, f == 0);
			chk("powerdown", output_buffer_powerdown_out, f[0]);
		end
		wr(8'h16, 8'h01);
		wr(8'h17, 8'hFF);
		chk("divider", output_divider_out, 9'h1FF);
		wr(8'h19, 8'hFA);
		wr(8'h1A, 8'h5C);
		chk("feedback", feedback_integer_ratio_out, 12'hA5C);
		wr(8'h1B, 8'hFF);
		wr(8'h1C, 8'h12);
		wr(8'h1D, 8'h34);
		chk("numerator", fraction_numerator_out, 22'h3F1234);
		wr(8'h1E, 8'h01);
		wr(8'h20, 8'h07);
		chk("denominator", fraction_denominator_out, 22'h010007);
		@(negedge clk_sys_in);
		chk("fraction on", fraction_active_out, 1'b1);
		wr(8'h1E, 8'h00);
		wr(8'h20, 8'h00);
		@(negedge clk_sys_in);
		chk("fraction off", fraction_active_out, 1'b0);
		wr(8'h30, 8'h5A);
		rd(8'h30, d);
		chk("unmapped read", d, 8'h00);
	endtask : t_fields
	// Measures between the first and second tick after the write, as a changed divider
	// may cut the first one short
	task automatic period(input logic [8:0] n);
		int c;
		wr(8'h16, {7'h00, n[8]});
		wr(8'h17, n[7:0]);
		for (int k = 0; k < 2; k++) begin
			c = 0;
			do begin
				@(negedge clk_sys_in);
				c++;
			end while (output_tick_out !== 1'b1 && c < 1100);
		end
		chk("tick period", c, n);
	endtask : period
	task automatic t_tick();
		int c;
		wr(8'h15, 8'h02);
		period(9'h005);
		chk("legal at minimum", output_divider_legal_out, 1'b1);
		period(9'h1FF);
		// High byte must be cleared too, or the ninth bit keeps the divider legal
		wr(8'h16, 8'h00);
		wr(8'h17, 8'h04);
		c = 0;
		repeat (20) begin
			@(negedge clk_sys_in);
			c += int'(output_tick_out !== 1'b0);
		end
		chk("reserved ticks", c, 0);
		chk("legal reserved", output_divider_legal_out, 1'b0);
	endtask : t_tick
	task automatic t_cal();
		logic [7:0] d;
		wr(8'h0A, 8'h02);
		chk("cal start", {calibration_start_out, calibration_busy_out}, 2'h3);
		rd(8'h0A, d);
		chk("cal read", d, 8'h02);
		wr(8'h0A, 8'h00);
		chk("cal busy", calibration_busy_out, 1'b1);
		wr(8'h0A, 8'h02);
		chk("cal restart", calibration_start_out, 1'b0);
		cal_done_in = 1'b1;
		repeat (4) @(negedge clk_sys_in);
		chk("cal done", calibration_busy_out, 1'b0);
		cal_done_in = 1'b0;
		repeat (4) @(negedge clk_sys_in);
		wr(8'h0A, 8'h02);
		chk("cal again", calibration_start_out, 1'b1);
	endtask : t_cal
	task automatic give_verdict();
		$display("compares %0d mismatches %0d", compares, mismatches);
		if (mismatches == 0 && compares > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask : give_verdict

	initial begin
		clk_sys_in = 1'b0;
		forever #2.5 clk_sys_in = ~clk_sys_in;
	end
	initial begin
		mismatches   = 0;
		compares     = 0;
		rst_b_in     = 1'b0;
		reg_addr_in  = 8'h00;
		reg_wdata_in = 8'h00;
		reg_write_in = 1'b0;
		reg_read_in  = 1'b0;
		cal_done_in  = 1'b0;
		repeat (5) @(negedge clk_sys_in);
		rst_b_in = 1'b1;
		t_reset();
		t_fields();
		t_tick();
		t_cal();
		give_verdict();
	end
	// Whole run is about 1200 cycles; the 20000-cycle limit allows many times that
	initial begin
		#100000;
		mismatches++;
		give_verdict();
	end
endmodule : tb

bind synth_divider_output_config synth_cfg_checker #(.OUT_DIV_WIDTH(OUT_DIV_WIDTH),
	.FB_DIV_WIDTH(FB_DIV_WIDTH), .FRAC_WIDTH(FRAC_WIDTH)) checker_inst (.clk_sys_in,
	.rst_b_in, .reg_addr_in, .reg_wdata_in, .reg_write_in, .crystal_margin_offset_out,
	.out_format_out, .out_tristate_out, .output_divider_out, .output_tick_out,
	.feedback_integer_ratio_out, .fraction_numerator_out, .fraction_denominator_out,
	.calibration_start_out, .calibration_busy_out);
